// File: design/ber_top.sv
`timescale 1ns/10ps
`default_nettype none
module ber_top
(
  input  wire logic                                         mclk,
  input  wire logic                                         srst,
  input  wire ber_pkg::ber_reg_req_s                        reg_req,
  output logic [ber_pkg::DATA_W-1:0]                        reg_rdata,
  input  wire ber_pkg::ber_event_s [ber_pkg::NUM_CODES-1:0] events,
  output logic                                              plic_irq,
  output logic                                              hart_irq,
  output logic                                              irq
);

  // software-visible state
  logic [ber_pkg::CAUSE_W-1:0]   cause;
  logic [ber_pkg::DATA_W-1:0]    err_addr;
  logic [ber_pkg::NUM_CODES-1:0] enable;
  logic [ber_pkg::NUM_CODES-1:0] plic_mask;
  logic [ber_pkg::NUM_CODES-1:0] accrued;
  logic [ber_pkg::NUM_CODES-1:0] hart_mask;
  logic [ber_pkg::IRQ_W-1:0]     irq_status;
  logic [ber_pkg::IRQ_W-1:0]     irq_mask;
  logic [ber_pkg::DROP_W-1:0]    drop_count;

  // event selection results
  logic [ber_pkg::NUM_CODES-1:0] hit;
  logic                          any_enabled;
  logic [ber_pkg::CAUSE_W-1:0]   pick_code;
  logic [ber_pkg::DATA_W-1:0]    pick_addr;

  // decoded strobes
  logic wr_cause;
  logic wr_addr;
  logic wr_enable;
  logic wr_plic;
  logic wr_accrued;
  logic wr_hart;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic wr_drop;

  // derived conditions and next values
  logic                          cause_empty;
  logic                          record;
  logic                          dropped;
  logic [ber_pkg::NUM_CODES-1:0] next_accrued;
  logic [ber_pkg::IRQ_W-1:0]     irq_set;
  logic [ber_pkg::IRQ_W-1:0]     irq_clr;
  logic [ber_pkg::IRQ_W-1:0]     next_irq_status;
  logic [ber_pkg::DROP_W-1:0]    next_drop_count;
  logic [ber_pkg::DATA_W-1:0]    next_rdata;

  ber_event_pick u_pick
  (
    .events      (events),
    .enable      (enable),
    .hit         (hit),
    .any_enabled (any_enabled),
    .pick_code   (pick_code),
    .pick_addr   (pick_addr)
  );

  // write decode; the master never raises both strobes at once
  always_comb
  begin
    wr_cause      = 1'b0;
    wr_addr       = 1'b0;
    wr_enable     = 1'b0;
    wr_plic       = 1'b0;
    wr_accrued    = 1'b0;
    wr_hart       = 1'b0;
    wr_irq_status = 1'b0;
    wr_irq_mask   = 1'b0;
    wr_drop       = 1'b0;
    if (reg_req.wr)
    begin
      case (reg_req.addr)
        ber_pkg::OFF_CAUSE:      wr_cause      = 1'b1;
        ber_pkg::OFF_ADDR:       wr_addr       = 1'b1;
        ber_pkg::OFF_ENABLE:     wr_enable     = 1'b1;
        ber_pkg::OFF_PLIC_MASK:  wr_plic       = 1'b1;
        ber_pkg::OFF_ACCRUED:    wr_accrued    = 1'b1;
        ber_pkg::OFF_HART_MASK:  wr_hart       = 1'b1;
        ber_pkg::OFF_IRQ_STATUS: wr_irq_status = 1'b1;
        ber_pkg::OFF_IRQ_MASK:   wr_irq_mask   = 1'b1;
        ber_pkg::OFF_DROP_COUNT: wr_drop       = 1'b1;
        default:                 wr_cause      = 1'b0;
      endcase
    end
  end

  // recording is armed only while the cause slot is empty
  assign cause_empty = (cause == ber_pkg::CAUSE_NONE);
  assign record      = any_enabled & cause_empty;
  // an enabled event that finds the slot already taken is lost
  assign dropped     = any_enabled & ~cause_empty;

  // cause: a latch in the same cycle as a software write wins,
  // so a write never overwrites an error latched into an empty slot; an event in the re-arm write cycle is dropped
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cause <= ber_pkg::RST_CAUSE;
    end
    else if (record)
    begin
      cause <= pick_code;
    end
    else if (wr_cause)
    begin
      cause <= reg_req.wdata[ber_pkg::CAUSE_W-1:0];
    end
  end

  // error address follows the cause latch to the cycle
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      err_addr <= ber_pkg::RST_ADDR;
    end
    else if (record)
    begin
      err_addr <= pick_addr;
    end
    else if (wr_addr)
    begin
      err_addr <= reg_req.wdata;
    end
  end

  // event enable mask
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      enable <= ber_pkg::RST_MASK;
    end
    else if (wr_enable)
    begin
      enable <= reg_req.wdata[ber_pkg::NUM_CODES-1:0];
    end
  end

  // platform and hart interrupt masks
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      plic_mask <= ber_pkg::RST_MASK;
      hart_mask <= ber_pkg::RST_MASK;
    end
    else
    begin
      if (wr_plic)
      begin
        plic_mask <= reg_req.wdata[ber_pkg::NUM_CODES-1:0];
      end
      if (wr_hart)
      begin
        hart_mask <= reg_req.wdata[ber_pkg::NUM_CODES-1:0];
      end
    end
  end

  // accrued ignores the enable mask; new events or over a write
  always_comb
  begin
    next_accrued = accrued;
    if (wr_accrued)
    begin
      next_accrued = reg_req.wdata[ber_pkg::NUM_CODES-1:0];
    end
    next_accrued = next_accrued | hit;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      accrued <= ber_pkg::RST_MASK;
    end
    else
    begin
      accrued <= next_accrued;
    end
  end

  // the block's own events: recorded, lost, uncorrectable seen
  always_comb
  begin
    irq_set = ber_pkg::RST_IRQ;
    irq_set[ber_pkg::IRQ_RECORDED] = record;
    irq_set[ber_pkg::IRQ_DROPPED]  = dropped;
    irq_set[ber_pkg::IRQ_UNCORR]   = hit[ber_pkg::CAUSE_DCACHE_UNCORR];
    irq_clr = wr_irq_status ? reg_req.wdata[ber_pkg::IRQ_W-1:0]
                            : ber_pkg::RST_IRQ;
    next_irq_status = (irq_status & ~irq_clr) | irq_set; // set wins
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      irq_status <= ber_pkg::RST_IRQ;
    end
    else
    begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      irq_mask <= ber_pkg::RST_IRQ;
    end
    else if (wr_irq_mask)
    begin
      irq_mask <= reg_req.wdata[ber_pkg::IRQ_W-1:0];
    end
  end

  // lost-event counter saturates rather than wrapping, so a storm
  // never reads back as a small number; a write clears it
  always_comb
  begin
    next_drop_count = drop_count;
    if (wr_drop)
    begin
      next_drop_count = ber_pkg::RST_DROP;
    end
    if (dropped && next_drop_count != ber_pkg::DROP_MAX)
    begin
      next_drop_count = next_drop_count + 16'h0001;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      drop_count <= ber_pkg::RST_DROP;
    end
    else
    begin
      drop_count <= next_drop_count;
    end
  end

  // read mux; unmapped offsets and unused upper bits read zero
  always_comb
  begin
    next_rdata = '0;
    case (reg_req.addr)
      ber_pkg::OFF_CAUSE:
        next_rdata[ber_pkg::CAUSE_W-1:0] = cause;
      ber_pkg::OFF_ADDR:
        next_rdata = err_addr;
      ber_pkg::OFF_ENABLE:
        next_rdata[ber_pkg::NUM_CODES-1:0] = enable;
      ber_pkg::OFF_PLIC_MASK:
        next_rdata[ber_pkg::NUM_CODES-1:0] = plic_mask;
      ber_pkg::OFF_ACCRUED:
        next_rdata[ber_pkg::NUM_CODES-1:0] = accrued;
      ber_pkg::OFF_HART_MASK:
        next_rdata[ber_pkg::NUM_CODES-1:0] = hart_mask;
      ber_pkg::OFF_IRQ_STATUS:
        next_rdata[ber_pkg::IRQ_W-1:0] = irq_status;
      ber_pkg::OFF_IRQ_MASK:
        next_rdata[ber_pkg::IRQ_W-1:0] = irq_mask;
      ber_pkg::OFF_DROP_COUNT:
        next_rdata[ber_pkg::DROP_W-1:0] = drop_count;
      default:
        next_rdata = '0;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      reg_rdata <= '0;
    end
    else if (reg_req.rd)
    begin
      reg_rdata <= next_rdata;
    end
    else
    begin
      reg_rdata <= '0;
    end
  end

  // interrupt levels straight from register state, no extra delay
  assign plic_irq = |(accrued & plic_mask);
  // the hart cannot mask or delegate this one (cause 128)
  assign hart_irq = |(accrued & hart_mask);
  assign irq      = |(irq_status & irq_mask);

endmodule
`default_nettype wire

// File: common/ber_pkg.sv
package ber_pkg;

  // bus and field widths
  localparam int DATA_W    = 64;
  localparam int ADDR_W    = 7;
  localparam int CAUSE_W   = 3;
  localparam int NUM_CODES = 8;
  localparam int IRQ_W     = 3;
  localparam int DROP_W    = 16;

  // register byte offsets, eight-byte stride
  localparam logic [ADDR_W-1:0] OFF_CAUSE      = 7'h00;
  localparam logic [ADDR_W-1:0] OFF_ADDR       = 7'h08;
  localparam logic [ADDR_W-1:0] OFF_ENABLE     = 7'h10;
  localparam logic [ADDR_W-1:0] OFF_PLIC_MASK  = 7'h18;
  localparam logic [ADDR_W-1:0] OFF_ACCRUED    = 7'h20;
  localparam logic [ADDR_W-1:0] OFF_HART_MASK  = 7'h28;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 7'h30;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK   = 7'h38;
  localparam logic [ADDR_W-1:0] OFF_DROP_COUNT = 7'h40;

  // cause codes; 1, 3 and 4 are reserved
  localparam logic [CAUSE_W-1:0] CAUSE_NONE          = 3'h0;
  localparam logic [CAUSE_W-1:0] CAUSE_ICACHE_CORR   = 3'h2;
  localparam logic [CAUSE_W-1:0] CAUSE_BUS_ERR       = 3'h5;
  localparam logic [CAUSE_W-1:0] CAUSE_DCACHE_CORR   = 3'h6;
  localparam logic [CAUSE_W-1:0] CAUSE_DCACHE_UNCORR = 3'h7;

  // codes that can actually be reported
  localparam logic [NUM_CODES-1:0] IMPL_CODES = 8'he4;

  // reset values
  localparam logic [CAUSE_W-1:0]   RST_CAUSE = 3'h0;
  localparam logic [DATA_W-1:0]    RST_ADDR  = 64'h0;
  localparam logic [NUM_CODES-1:0] RST_MASK  = 8'h00;
  localparam logic [IRQ_W-1:0]     RST_IRQ   = 3'h0;
  localparam logic [DROP_W-1:0]    RST_DROP  = 16'h0000;
  localparam logic [DROP_W-1:0]    DROP_MAX  = 16'hffff;

  // bit positions of the block's own interrupt status
  localparam int IRQ_RECORDED = 0;
  localparam int IRQ_DROPPED  = 1;
  localparam int IRQ_UNCORR   = 2;

  // cause number the hart uses for the local error interrupt
  localparam int HART_IRQ_CAUSE = 128;

  // one event source, indexed by its cause code
  typedef struct packed {
    logic              valid;
    logic              addr_known;
    logic [DATA_W-1:0] addr;
  } ber_event_s;

  // register port request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ber_reg_req_s;

endpackage

// File: design/ber_event_pick.sv
`timescale 1ns/10ps
`default_nettype none
module ber_event_pick
(
  input  wire ber_pkg::ber_event_s [ber_pkg::NUM_CODES-1:0] events,
  input  wire logic [ber_pkg::NUM_CODES-1:0]                enable,
  output logic [ber_pkg::NUM_CODES-1:0]                     hit,
  output logic                                              any_enabled,
  output logic [ber_pkg::CAUSE_W-1:0]                       pick_code,
  output logic [ber_pkg::DATA_W-1:0]                        pick_addr
);

  logic [ber_pkg::NUM_CODES-1:0] en_hit;

  // reserved codes never report, whatever the source drives
  genvar g;
  generate
    for (g = 0; g < ber_pkg::NUM_CODES; g++)
    begin : g_hit
      assign hit[g]    = events[g].valid & ber_pkg::IMPL_CODES[g];
      assign en_hit[g] = hit[g] & enable[g];
    end
  endgenerate

  assign any_enabled = |en_hit;

  // highest code wins a tie, so an uncorrectable error beats the rest
  always_comb
  begin
    pick_code = ber_pkg::CAUSE_NONE;
    pick_addr = ber_pkg::RST_ADDR;
    for (int i = 0; i < ber_pkg::NUM_CODES; i++)
    begin
      if (en_hit[i])
      begin
        pick_code = ber_pkg::CAUSE_W'(i);
        pick_addr = events[i].addr_known ? events[i].addr
                                         : ber_pkg::RST_ADDR;
      end
    end
  end

endmodule
`default_nettype wire

// File: testbench/ber_src_model.sv
`timescale 1ns/10ps
`default_nettype none
module ber_src_model
(
  input  wire logic [7:0]               fire,
  input  wire logic [63:0]              addr,
  input  wire logic                     known,
  input  wire logic                     hart_irq,
  output var ber_pkg::ber_event_s [7:0] events,
  output logic [7:0]                    taken_cause
);
  // idle lines show inverted values so a stale address never matches
  always_comb
    for (int i = 0; i < 8; i++)
    begin
      events[i].valid      = fire[i];
      events[i].addr_known = fire[i] ? known : ~known;
      events[i].addr       = fire[i] ? addr : ~addr;
    end
  // hart side takes the local error interrupt, always enabled
  assign taken_cause = hart_irq ? 8'h80 : 8'h00;
endmodule
`default_nettype wire

// File: testbench/ber_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module ber_monitor
(
  input wire logic                     mclk,
  input wire logic                     srst,
  input wire ber_pkg::ber_reg_req_s    reg_req,
  input wire logic [63:0]              reg_rdata,
  input wire ber_pkg::ber_event_s [7:0] events,
  input wire logic                     plic_irq,
  input wire logic                     hart_irq,
  input wire logic                     irq
);
  logic ev;
  logic rd_mask;
  // any reportable event this cycle; other indices are ignored
  assign ev = events[2].valid | events[5].valid | events[6].valid
            | events[7].valid;
  assign rd_mask = reg_req.rd && reg_req.addr >= 7'h10
                && reg_req.addr <= 7'h28 && reg_req.addr[2:0] == 3'h0;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  a_reset_quiet: assert property (disable iff (1'b0) srst |=>
    !plic_irq && !hart_irq && !irq) else $error("irq after reset");
  a_rdata_idle: assert property (!reg_req.rd |=> reg_rdata == 64'h0)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (reg_req.rd && (reg_req.addr > 7'h40
    || reg_req.addr[2:0] != 3'h0) |=> reg_rdata == 64'h0)
    else $error("unmapped read not zero");
  a_cause_width: assert property (reg_req.rd && reg_req.addr == 7'h00
    |=> reg_rdata[63:3] == 61'h0) else $error("cause too wide");
  a_mask_width: assert property (rd_mask |=> reg_rdata[63:8] == 56'h0)
    else $error("mask too wide");
  a_plic_hold: assert property (plic_irq && !reg_req.wr |=> plic_irq)
    else $error("platform irq dropped without write");
  a_plic_cause: assert property (!plic_irq && !reg_req.wr && !ev
    |=> !plic_irq) else $error("platform irq without cause");
  a_hart_hold: assert property (hart_irq && !reg_req.wr |=> hart_irq)
    else $error("hart irq dropped without write");
  a_hart_cause: assert property (!hart_irq && !reg_req.wr && !ev
    |=> !hart_irq) else $error("hart irq without cause");
  c_plic: cover property ($rose(plic_irq));
  c_hart: cover property ($rose(hart_irq));
  c_irq: cover property ($rose(irq));
endmodule
bind ber_top ber_monitor ber_monitor_i (.mclk(mclk), .srst(srst),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .events(events),
  .plic_irq(plic_irq), .hart_irq(hart_irq), .irq(irq));
`default_nettype wire

// File: testbench/ber_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ber_top_tb;
  logic                      mclk, srst, known, plic_irq, hart_irq, irq;
  logic [7:0]                fire, acc, en, pm, hm;
  logic [2:0]                cause;
  logic [63:0]               addr, eaddr, reg_rdata, d;
  ber_pkg::ber_reg_req_s     reg_req;
  ber_pkg::ber_event_s [7:0] events;
  integer                    seed, err_count, total_checks, cyc;
  ber_top ber_top_i (.mclk(mclk), .srst(srst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .events(events), .plic_irq(plic_irq),
    .hart_irq(hart_irq), .irq(irq));
  ber_src_model ber_src_model_i (.fire(fire), .addr(addr), .known(known),
    .hart_irq(hart_irq), .events(events), .taken_cause());
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [63:0] v);
    @(posedge mclk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge mclk);
    reg_req.wr <= 1'b0;
    #1;
  endtask
  task automatic wr_rand(input logic [6:0] a);
    d = {$random(seed), $random(seed)};
    wr(a, d);
  endtask
  task automatic rd(input logic [6:0] a, input logic [63:0] exp);
    @(posedge mclk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 64'h0};
    @(posedge mclk);
    reg_req.rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // one-cycle event burst; expected state follows the recording rules
  task automatic fire_ev(input logic [7:0] v, input logic [63:0] a,
                         input logic k);
    logic [7:0] h;
    h = v & en & 8'he4;
    @(posedge mclk);
    fire <= v;
    addr <= a;
    known <= k;
    @(posedge mclk);
    fire <= 8'h00;
    acc = acc | (v & 8'he4);
    if (cause == 3'h0 && h != 8'h00)
    begin
      cause = h[7] ? 3'h7 : h[6] ? 3'h6 : h[5] ? 3'h5 : 3'h2;
      eaddr = k ? a : 64'h0;
    end
  endtask
  task automatic chk_all;
    rd(7'h00, {61'h0, cause});
    rd(7'h08, eaddr);
    rd(7'h10, {56'h0, en});
    rd(7'h18, {56'h0, pm});
    rd(7'h20, {56'h0, acc});
    rd(7'h28, {56'h0, hm});
    chk({63'h0, plic_irq}, {63'h0, |(acc & pm)});
    chk({63'h0, hart_irq}, {63'h0, |(acc & hm)});
  endtask
  // free-running clock, 4 ns period
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // hang guard
  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 8000)
    begin
      err_count++;
      close_out;
    end
  end
  // main sequence
  initial
  begin
    {seed, err_count, total_checks, cyc} = {32'd53063, 96'd0};
    // reset gets its own line: a wide concatenation would cut it off
    srst = 1'b1;
    {fire, addr, known, reg_req} = 146'h0;
    {cause, eaddr, en, pm, hm, acc} = 99'h0;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    chk_all;
    rd(7'h48, 64'h0);
    rd(7'h04, 64'h0);
    for (int i = 0; i < 40; i++)
    begin
      wr_rand(7'h10);
      en = d[7:0];
      wr_rand(7'h18);
      pm = d[7:0];
      wr_rand(7'h28);
      hm = d[7:0];
      if (i % 3 == 0)
        wr(7'h00, 64'h0);
      if (i % 3 == 0)
        cause = 3'h0;
      if (i % 7 == 5)
        wr_rand(7'h00);
      if (i % 7 == 5)
        cause = d[2:0];
      if (i % 5 == 1)
        wr_rand(7'h20);
      if (i % 5 == 1)
        acc = d[7:0];
      if (i % 6 == 2)
        wr_rand(7'h08);
      if (i % 6 == 2)
        eaddr = d;
      fire_ev(8'($random(seed)), {$random(seed), $random(seed)},
              1'($random(seed)));
      chk_all;
    end
    // mid-run reset from a busy state must clear everything again
    @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    {cause, eaddr, en, pm, hm, acc} = 99'h0;
    chk_all;
    // block interrupt: raise, mask, unmask, clear
    wr(7'h00, 64'h0);
    wr(7'h10, 64'hff);
    en = 8'hff;
    wr(7'h38, 64'h1);
    fire_ev(8'h20, 64'h1234, 1'b1);
    #1 chk({63'h0, irq}, 64'h1);
    wr(7'h38, 64'h0);
    chk({63'h0, irq}, 64'h0);
    wr(7'h38, 64'h1);
    chk({63'h0, irq}, 64'h1);
    wr(7'h30, 64'h7);
    chk({63'h0, irq}, 64'h0);
    // slot still taken: code 7 is lost, counted and flagged
    fire_ev(8'h80, 64'h55, 1'b0);
    rd(7'h00, {61'h0, cause});
    rd(7'h08, eaddr);
    rd(7'h20, {56'h0, acc});
    rd(7'h30, 64'h6);
    rd(7'h40, 64'h1);
    close_out;
  end
endmodule
`default_nettype wire
